// ---- design/slvds_fmt_cfg.sv ----
// Configuration registers of the serial output formatter, with the width path.
// Assumes register access, sample source and DSP enable all run on I_SYS_CLK.
`timescale 1ns/1ps
module slvds_fmt_cfg
    import slvds_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RSTN,
    input wire logic I_CE,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    input wire logic I_DSP_PATH_EN,
    input wire logic I_SMP_VALID,
    output logic O_SMP_READY,
    input wire slvds_pkg::slvds_sample_s I_SMP,
    output logic O_WORD_VALID,
    input wire logic I_WORD_READY,
    output slvds_pkg::slvds_word_s O_WORD,
    output logic O_FRAME_CLOCK_SOURCE_SEL,
    output logic O_FRAME_CLOCK_DIVIDE_SEL,
    output logic O_FRAME_CLOCK_TOGGLE_SEL,
    output logic O_HALF_SWING,
    output logic signed [2:0] O_LANE_DELAY_STEPS,
    output logic signed [2:0] O_BIT_CLOCK_DELAY_STEPS,
    output logic [19:0] O_FRAME_MARKER_PATTERN,
    output logic O_SCRAMBLER_ACTIVE,
    output slvds_pkg::slvds_width_e O_ACTIVE_WIDTH
);

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RSTN);

    slvds_cfg_s cfg_reg, cfg_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    slvds_width_e width_reg, width_next;
    slvds_width_e sel_width;
    slvds_word_s sel_word;
    logic wr_en;

    assign wr_en = I_CE && I_REG_WR;

    // Register writes; reserved bits are not stored and read back as zero.
    always_comb begin
        cfg_next = cfg_reg;
        if (wr_en) begin
            case (I_REG_ADDR)
                ADDR_FRAME_CFG: begin
                    cfg_next.src_sel = I_REG_WDATA[FRAME_CLOCK_SOURCE_SEL_BIT];
                    cfg_next.div_sel = I_REG_WDATA[FRAME_CLOCK_DIVIDE_SEL_BIT];
                    cfg_next.tog_sel = I_REG_WDATA[FRAME_CLOCK_TOG_BIT];
                end
                ADDR_SWING: begin
                    cfg_next.half_swing = I_REG_WDATA[HALF_SWING_BIT];
                end
                ADDR_RESOLUTION: begin
                    cfg_next.wsel_en = I_REG_WDATA[WSEL_EN_BIT];
                    cfg_next.wide_en = I_REG_WDATA[WIDE_EN_BIT];
                    cfg_next.wcode = I_REG_WDATA[WCODE_LSB +: 3];
                end
                ADDR_DELAY: begin
                    cfg_next.lane_del = I_REG_WDATA[LANE_DEL_LSB +: 2];
                    cfg_next.bclk_del = I_REG_WDATA[BCLK_DEL_LSB +: 2];
                end
                ADDR_PAT_LOW: begin
                    cfg_next.pattern[7:0] = I_REG_WDATA;
                end
                ADDR_PAT_MID: begin
                    cfg_next.pattern[15:8] = I_REG_WDATA;
                end
                ADDR_PAT_HIGH: begin
                    cfg_next.pattern[19:16] = I_REG_WDATA[3:0];
                    cfg_next.scrambler_enable = I_REG_WDATA[SCRAMBLER_ENABLE_BIT];
                end
                default: begin
                    cfg_next = cfg_reg;
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cfg_reg.src_sel <= CTRL_BIT_RST;
            cfg_reg.div_sel <= CTRL_BIT_RST;
            cfg_reg.tog_sel <= CTRL_BIT_RST;
            cfg_reg.half_swing <= CTRL_BIT_RST;
            cfg_reg.wsel_en <= CTRL_BIT_RST;
            cfg_reg.wide_en <= CTRL_BIT_RST;
            cfg_reg.wcode <= WCODE_RST;
            cfg_reg.lane_del <= DELAY_RST;
            cfg_reg.bclk_del <= DELAY_RST;
            cfg_reg.pattern <= PATTERN_RST;
            cfg_reg.scrambler_enable <= CTRL_BIT_RST;
        end else if (I_CE) begin
            cfg_reg <= cfg_next;
        end
    end

    // Read port: data and valid come one cycle after the request.
    always_comb begin
        rdata_next = 8'h00;
        rvalid_next = I_REG_RD;
        if (I_REG_RD) begin
            case (I_REG_ADDR)
                ADDR_FRAME_CFG: begin
                    rdata_next[FRAME_CLOCK_SOURCE_SEL_BIT] = cfg_reg.src_sel;
                    rdata_next[FRAME_CLOCK_DIVIDE_SEL_BIT] = cfg_reg.div_sel;
                    rdata_next[FRAME_CLOCK_TOG_BIT] = cfg_reg.tog_sel;
                end
                ADDR_SWING: begin
                    rdata_next[HALF_SWING_BIT] = cfg_reg.half_swing;
                end
                ADDR_RESOLUTION: begin
                    rdata_next[WSEL_EN_BIT] = cfg_reg.wsel_en;
                    rdata_next[WIDE_EN_BIT] = cfg_reg.wide_en;
                    rdata_next[WCODE_LSB +: 3] = cfg_reg.wcode;
                end
                ADDR_DELAY: begin
                    rdata_next[LANE_DEL_LSB +: 2] = cfg_reg.lane_del;
                    rdata_next[BCLK_DEL_LSB +: 2] = cfg_reg.bclk_del;
                end
                ADDR_PAT_LOW: begin
                    rdata_next = cfg_reg.pattern[7:0];
                end
                ADDR_PAT_MID: begin
                    rdata_next = cfg_reg.pattern[15:8];
                end
                ADDR_PAT_HIGH: begin
                    rdata_next[3:0] = cfg_reg.pattern[19:16];
                    rdata_next[SCRAMBLER_ENABLE_BIT] = cfg_reg.scrambler_enable;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else if (I_CE) begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // Effective width, registered so the frame logic sees a stable level.
    always_comb begin
        width_next = sel_width;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            width_reg <= WIDTH_18;
        end else if (I_CE) begin
            width_reg <= width_next;
        end
    end

    // Width selection honours the enable only when the DSP path is off.
    slvds_width_sel u_width_sel (
        .i_dsp_en (I_DSP_PATH_EN),
        .i_wsel_en (cfg_reg.wsel_en),
        .i_wide_en (cfg_reg.wide_en),
        .i_wcode (cfg_reg.wcode),
        .i_sample (I_SMP),
        .o_width (sel_width),
        .o_word (sel_word)
    );

    // Buffer absorbs a receiver stall without losing a word.
    slvds_skid_buf u_skid_buf (
        .i_clk (I_SYS_CLK),
        .i_rstn (I_RSTN),
        .i_ce (I_CE),
        .i_valid (I_SMP_VALID),
        .o_ready (O_SMP_READY),
        .i_word (sel_word),
        .o_valid (O_WORD_VALID),
        .i_ready (I_WORD_READY),
        .o_word (O_WORD)
    );

    assign O_REG_RDATA = rdata_reg;
    assign O_REG_RVALID = rvalid_reg;
    assign O_FRAME_CLOCK_SOURCE_SEL = cfg_reg.src_sel;
    assign O_FRAME_CLOCK_DIVIDE_SEL = cfg_reg.div_sel;
    assign O_FRAME_CLOCK_TOGGLE_SEL = cfg_reg.tog_sel;
    assign O_HALF_SWING = cfg_reg.half_swing;
    assign O_LANE_DELAY_STEPS = slvds_delay_steps(cfg_reg.lane_del);
    assign O_BIT_CLOCK_DELAY_STEPS = slvds_delay_steps(cfg_reg.bclk_del);
    assign O_FRAME_MARKER_PATTERN = cfg_reg.pattern;
    assign O_SCRAMBLER_ACTIVE = cfg_reg.scrambler_enable && I_DSP_PATH_EN;
    assign O_ACTIVE_WIDTH = width_reg;

    sequence s_wr(logic [7:0] a);
        I_CE && I_REG_WR && (I_REG_ADDR == a);
    endsequence

    sequence s_rd(logic [7:0] a);
        I_CE && I_REG_RD && (I_REG_ADDR == a);
    endsequence

    sequence s_pattern_load;
        s_wr(ADDR_PAT_LOW) ##1 s_wr(ADDR_PAT_MID) ##1 s_wr(ADDR_PAT_HIGH);
    endsequence

    a_frame_cfg_map: assert property (
        s_wr(ADDR_FRAME_CFG) |=> {O_FRAME_CLOCK_SOURCE_SEL, O_FRAME_CLOCK_DIVIDE_SEL,
            O_FRAME_CLOCK_TOGGLE_SEL} == {$past(I_REG_WDATA[7]), $past(I_REG_WDATA[4]),
            $past(I_REG_WDATA[0])})
        else $error("Frame clock selects do not follow bits 7, 4 and 0.");

    a_swing_bit: assert property (
        s_wr(ADDR_SWING) |=> O_HALF_SWING == $past(I_REG_WDATA[6]))
        else $error("Swing reduction does not follow bit 6.");

    a_width_ignored: assert property (
        (!cfg_reg.wide_en && !cfg_reg.wsel_en && !I_DSP_PATH_EN && I_CE)
            |=> O_ACTIVE_WIDTH == WIDTH_18)
        else $error("Width code took effect without its enable.");

    a_width_enable: assert property (
        (!cfg_reg.wide_en && cfg_reg.wsel_en && cfg_reg.wcode == 3'b010 && I_CE)
            |=> O_ACTIVE_WIDTH == WIDTH_14)
        else $error("Enabled width select did not apply code 010.");

    a_wide_mode: assert property (
        s_wr(ADDR_RESOLUTION) ##0 I_REG_WDATA[WIDE_EN_BIT] ##1 I_CE
            |=> O_ACTIVE_WIDTH == WIDTH_20)
        else $error("20-bit mode not active after setting bit 6.");

    a_code_sixteen: assert property (
        (I_SMP_VALID && O_SMP_READY && (I_DSP_PATH_EN || cfg_reg.wsel_en) && !cfg_reg.wide_en
            && cfg_reg.wcode == 3'b001) |-> sel_word.width == WIDTH_16
            && sel_word.data[3:0] == 4'h0)
        else $error("Code 001 did not give a 16-bit word.");

    a_lane_trim: assert property (
        s_wr(ADDR_DELAY) ##0 I_REG_WDATA[3:2] == 2'b11 |=> O_LANE_DELAY_STEPS == 3'sd2)
        else $error("Lane trim 11 is not two delay steps.");

    a_clock_trim: assert property (
        s_wr(ADDR_DELAY) ##0 I_REG_WDATA[1:0] == 2'b01 |=> O_BIT_CLOCK_DELAY_STEPS == -3'sd1)
        else $error("Bit clock trim 01 is not one step of advance.");

    a_pattern_build: assert property (
        s_pattern_load |=> O_FRAME_MARKER_PATTERN == {$past(I_REG_WDATA[3:0]),
            $past(I_REG_WDATA, 2), $past(I_REG_WDATA, 3)})
        else $error("Frame marker pattern not assembled from the three registers.");

    a_scrambler_gate: assert property (
        O_SCRAMBLER_ACTIVE |-> I_DSP_PATH_EN && cfg_reg.scrambler_enable)
        else $error("Scrambler active without DSP path enable.");

    a_scrambler_on: assert property (
        s_wr(ADDR_PAT_HIGH) ##0 I_REG_WDATA[SCRAMBLER_ENABLE_BIT] |=> O_SCRAMBLER_ACTIVE == I_DSP_PATH_EN)
        else $error("Stored scrambler bit not gated by the DSP path enable.");

    a_wide_no_select: assert property (
        (cfg_reg.wide_en && !cfg_reg.wsel_en && I_CE) |=> O_ACTIVE_WIDTH == WIDTH_20)
        else $error("20-bit mode needed the width select enable.");

    a_read_answer: assert property (
        I_CE && I_REG_RD |=> O_REG_RVALID)
        else $error("Read request got no answer in the next cycle.");

    a_rvalid_single: assert property (
        I_CE && !I_REG_RD |=> !O_REG_RVALID)
        else $error("Read answer without a read request.");

    a_read_pattern: assert property (
        s_rd(ADDR_PAT_MID) |=> O_REG_RDATA == $past(O_FRAME_MARKER_PATTERN[15:8]))
        else $error("Middle pattern byte read back wrong.");

    a_swing_read: assert property (
        s_rd(ADDR_SWING) |=> O_REG_RDATA == {1'b0, $past(O_HALF_SWING), 6'h00})
        else $error("Swing register read back wrong.");

    a_delay_reserved: assert property (
        s_rd(ADDR_DELAY) |=> O_REG_RDATA[7:4] == 4'h0)
        else $error("Reserved bits of the trim register read back set.");

    a_unmapped_read: assert property (
        s_rd(ADDR_PAT_HIGH + 8'h01) |=> O_REG_RDATA == 8'h00)
        else $error("Unmapped address read back nonzero.");

    // A low clock enable must hold the frame marker pattern and the active width.
    a_clock_freeze: assert property (
        !I_CE |=> $stable(O_FRAME_MARKER_PATTERN) && $stable(O_ACTIVE_WIDTH))
        else $error("Configuration changed while the clock enable was low.");

endmodule

// ---- common/slvds_pkg.sv ----
// Shared constants, types and helpers for the serial output formatter configuration block.
// Assumes a single system clock domain; all users import this package whole.
package slvds_pkg;

    // Register addresses.
    localparam logic [7:0] ADDR_FRAME_CFG = 8'h19;
    localparam logic [7:0] ADDR_SWING = 8'h1a;
    localparam logic [7:0] ADDR_RESOLUTION = 8'h1b;
    localparam logic [7:0] ADDR_DELAY = 8'h1e;
    localparam logic [7:0] ADDR_PAT_LOW = 8'h20;
    localparam logic [7:0] ADDR_PAT_MID = 8'h21;
    localparam logic [7:0] ADDR_PAT_HIGH = 8'h22;

    // Field positions.
    localparam int FRAME_CLOCK_SOURCE_SEL_BIT = 7;
    localparam int FRAME_CLOCK_DIVIDE_SEL_BIT = 4;
    localparam int FRAME_CLOCK_TOG_BIT = 0;
    localparam int HALF_SWING_BIT = 6;
    localparam int WSEL_EN_BIT = 7;
    localparam int WIDE_EN_BIT = 6;
    localparam int WCODE_LSB = 3;
    localparam int LANE_DEL_LSB = 2;
    localparam int BCLK_DEL_LSB = 0;
    localparam int SCRAMBLER_ENABLE_BIT = 6;
    localparam int PAT_HIGH_LSB = 16;

    // Reset values.
    localparam logic CTRL_BIT_RST = 1'b0;
    localparam logic [2:0] WCODE_RST = 3'h0;
    localparam logic [1:0] DELAY_RST = 2'h0;
    localparam logic [19:0] PATTERN_RST = 20'hffc00;

    // One delay step of the lane and bit-clock trims, in picoseconds.
    localparam int DELAY_STEP_PS = 50;

    // Keep masks for MSB-aligned output words.
    localparam logic [19:0] MASK_14 = 20'hfffc0;
    localparam logic [19:0] MASK_16 = 20'hffff0;
    localparam logic [19:0] MASK_18 = 20'hffffc;
    localparam logic [19:0] MASK_20 = 20'hfffff;

    typedef enum logic [2:0] {
        WCODE_18 = 3'b000,
        WCODE_16 = 3'b001,
        WCODE_14 = 3'b010
    } slvds_wcode_e;

    typedef enum logic [1:0] {
        WIDTH_14 = 2'b00,
        WIDTH_16 = 2'b01,
        WIDTH_18 = 2'b10,
        WIDTH_20 = 2'b11
    } slvds_width_e;

    typedef struct packed {
        logic [19:0] data;
    } slvds_sample_s;

    typedef struct packed {
        logic [19:0] data;
        slvds_width_e width;
    } slvds_word_s;

    typedef struct packed {
        logic src_sel;
        logic div_sel;
        logic tog_sel;
        logic half_swing;
        logic wsel_en;
        logic wide_en;
        logic [2:0] wcode;
        logic [1:0] lane_del;
        logic [1:0] bclk_del;
        logic [19:0] pattern;
        logic scrambler_enable;
    } slvds_cfg_s;

    // Signed trim in delay steps: positive delays, negative advances.
    function automatic logic signed [2:0] slvds_delay_steps(input logic [1:0] code);
        case (code)
            2'b01: slvds_delay_steps = -3'sd1;
            2'b10: slvds_delay_steps = 3'sd1;
            2'b11: slvds_delay_steps = 3'sd2;
            default: slvds_delay_steps = 3'sd0;
        endcase
    endfunction

endpackage

// ---- design/slvds_width_sel.sv ----
// Output width selection: picks the effective word width and masks the sample.
// Assumes samples arrive MSB aligned in 20 bits; purely combinational.
`timescale 1ns/1ps
module slvds_width_sel
    import slvds_pkg::*;
(
    input wire logic i_dsp_en,
    input wire logic i_wsel_en,
    input wire logic i_wide_en,
    input wire logic [2:0] i_wcode,
    input wire slvds_pkg::slvds_sample_s i_sample,
    output slvds_pkg::slvds_width_e o_width,
    output slvds_pkg::slvds_word_s o_word
);
    always_comb begin
        o_width = WIDTH_18;
        if (i_wide_en) begin
            o_width = WIDTH_20;
        end else if (i_dsp_en || i_wsel_en) begin
            // Unlisted codes fall back to the native width.
            case (i_wcode)
                WCODE_16: o_width = WIDTH_16;
                WCODE_14: o_width = WIDTH_14;
                default: o_width = WIDTH_18;
            endcase
        end
        o_word.width = o_width;
        case (o_width)
            WIDTH_14: o_word.data = i_sample.data & MASK_14;
            WIDTH_16: o_word.data = i_sample.data & MASK_16;
            WIDTH_20: o_word.data = i_sample.data & MASK_20;
            default: o_word.data = i_sample.data & MASK_18;
        endcase
    end
endmodule

// ---- design/slvds_skid_buf.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; a low clock enable freezes it and drops both handshakes.
`timescale 1ns/1ps
module slvds_skid_buf
    import slvds_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_valid,
    output logic o_ready,
    input wire slvds_pkg::slvds_word_s i_word,
    output logic o_valid,
    input wire logic i_ready,
    output slvds_pkg::slvds_word_s o_word
);
    slvds_word_s mem_reg [2];
    slvds_word_s mem_next [2];
    logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [1:0] count_reg, count_next;
    logic push, pop;

    assign o_ready = i_ce && (count_reg != 2'd2);
    assign o_valid = i_ce && (count_reg != 2'd0);
    assign o_word = mem_reg[rd_ptr_reg];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        mem_next = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = i_word;
            wr_ptr_next = ~wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        case ({push, pop})
            2'b10: count_next = count_reg + 2'd1;
            2'b01: count_next = count_reg - 2'd1;
            default: count_next = count_reg;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'd0;
        end else if (i_ce) begin
            mem_reg <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end
endmodule

// ---- bench/slvds_rx_model.sv ----
// Behavioural receiver standing at the far side of the formatted word stream.
// Assumes one clock; the bench stalls it through i_stall, driven at the falling edge.
`timescale 1ns/1ps
module slvds_rx_model
    import slvds_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_stall,
    input wire logic i_valid,
    input wire slvds_pkg::slvds_word_s i_word,
    output logic o_ready,
    output logic o_hold_err
);
    import slvds_pkg::*;

    slvds_word_s got_q[$];
    slvds_word_s last_word;
    logic was_held;

    assign o_ready = !i_stall;

    // A word offered during a stall must still be the same word on the next cycle.
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            got_q.delete();
            was_held <= 1'b0;
            o_hold_err <= 1'b0;
            last_word <= '0;
        end else begin
            if (i_valid && o_ready) begin
                got_q.push_back(i_word);
            end
            if (was_held && i_word !== last_word) begin
                o_hold_err <= 1'b1;
            end
            was_held <= i_valid && !o_ready;
            last_word <= i_word;
        end
    end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench of the formatter configuration block and its word buffer.
// Assumes the receiver model beside it; inputs change at the falling edge, except one dsp change 1 ns after it.
`timescale 1ns/1ps
module tb;
    import slvds_pkg::*;

    logic clk, rstn, ce, wr, rd, dsp, smp_valid, stall;
    logic [7:0] addr, wdata, rdata;
    logic rvalid, smp_ready, word_valid, word_ready, hold_err;
    logic src, div, tog, half, scr;
    logic signed [2:0] lane_st, bclk_st;
    logic [19:0] pat;
    slvds_sample_s smp;
    slvds_word_s word, got;
    slvds_width_e act_w;
    int num_errors = 0;
    int checked = 0;
    logic [7:0] addr_t[7] = '{8'h19, 8'h1a, 8'h1b, 8'h1e, 8'h20, 8'h21, 8'h22};
    logic [7:0] rst_t[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfc, 8'h0f};
    logic [7:0] fc_t[4] = '{8'h10, 8'h00, 8'h80, 8'h01};
    logic [2:0] step_t[4] = '{3'h0, 3'h7, 3'h1, 3'h2};
    logic dsp_t[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [7:0] cfg_t[7] = '{8'h80, 8'h88, 8'h90, 8'h10, 8'h10, 8'h40, 8'hb8};
    logic [1:0] w_t[7] = '{2'b10, 2'b01, 2'b00, 2'b10, 2'b00, 2'b11, 2'b10};
    logic [19:0] d_t[7] = '{20'habcdc, 20'habcd0, 20'habcc0, 20'habcdc, 20'habcc0,
                            20'habcde, 20'habcdc};

    slvds_fmt_cfg dut (
        .I_SYS_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
        .I_DSP_PATH_EN(dsp), .I_SMP_VALID(smp_valid), .O_SMP_READY(smp_ready), .I_SMP(smp),
        .O_WORD_VALID(word_valid), .I_WORD_READY(word_ready), .O_WORD(word),
        .O_FRAME_CLOCK_SOURCE_SEL(src), .O_FRAME_CLOCK_DIVIDE_SEL(div),
        .O_FRAME_CLOCK_TOGGLE_SEL(tog), .O_HALF_SWING(half),
        .O_LANE_DELAY_STEPS(lane_st), .O_BIT_CLOCK_DELAY_STEPS(bclk_st),
        .O_FRAME_MARKER_PATTERN(pat), .O_SCRAMBLER_ACTIVE(scr), .O_ACTIVE_WIDTH(act_w)
    );

    slvds_rx_model rx (
        .i_clk(clk), .i_rstn(rstn), .i_stall(stall), .i_valid(word_valid),
        .i_word(word), .o_ready(word_ready), .o_hold_err(hold_err)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        check({31'h0, rvalid}, 32'h1);
        check({24'h0, rdata}, {24'h0, exp});
    endtask

    // Called at a falling edge; leaves valid high so bursts run back to back.
    task automatic push(input logic [19:0] d);
        int n;
        n = 0;
        smp = d;
        smp_valid = 1'b1;
        while (smp_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
    endtask

    task automatic pop(input logic [19:0] d, input logic [1:0] w);
        check(rx.got_q.size(), 32'h1);
        got = rx.got_q.pop_front();
        check({10'h0, got}, {10'h0, d, w});
    endtask

    initial begin
        #20000;
        num_errors++;
        final_report();
    end

    initial begin
        rstn = 1'b0;
        {ce, wr, rd, dsp, smp_valid, stall} = 6'b100000;
        addr = 8'h00;
        wdata = 8'h00;
        smp = '0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        check({30'h0, act_w}, {30'h0, WIDTH_18});
        check({12'h0, pat}, 32'hffc00);
        check({31'h0, word_valid}, 32'h0);
        for (int i = 0; i < 7; i++) reg_rd(addr_t[i], rst_t[i]);
        reg_rd(8'h23, 8'h00);
        $display("test reset done");

        reg_wr(8'h19, 8'hff);
        check({29'h0, src, div, tog}, 32'h7);
        reg_rd(8'h19, 8'h91);
        for (int i = 0; i < 4; i++) begin
            reg_wr(8'h19, fc_t[i]);
            check({29'h0, src, div, tog}, {29'h0, fc_t[i][7], fc_t[i][4], fc_t[i][0]});
        end
        $display("test frame clock done");

        reg_wr(8'h1a, 8'hff);
        check({31'h0, half}, 32'h1);
        reg_rd(8'h1a, 8'h40);
        reg_wr(8'h1a, 8'h00);
        check({31'h0, half}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            reg_wr(8'h1e, {4'hf, i[1:0], ~i[1:0]});
            check({29'h0, lane_st}, {29'h0, step_t[i]});
            check({29'h0, bclk_st}, {29'h0, step_t[3 - i]});
        end
        reg_rd(8'h1e, 8'h0c);
        $display("test swing and delay done");

        // Back-to-back writes of the three pattern bytes.
        @(negedge clk);
        {wr, addr, wdata} = {1'b1, 8'h20, 8'h5a};
        @(negedge clk);
        {addr, wdata} = {8'h21, 8'hc3};
        @(negedge clk);
        {addr, wdata} = {8'h22, 8'hf7};
        @(negedge clk);
        wr = 1'b0;
        check({12'h0, pat}, 32'h7c35a);
        reg_rd(8'h22, 8'h47);
        check({31'h0, scr}, 32'h0);
        dsp = 1'b1;
        #1;
        check({31'h0, scr}, 32'h1);
        $display("test pattern done");

        for (int i = 0; i < 7; i++) begin
            dsp = dsp_t[i];
            reg_wr(8'h1b, cfg_t[i]);
            @(negedge clk);
            check({30'h0, act_w}, {30'h0, w_t[i]});
            push(20'habcde);
            smp_valid = 1'b0;
            repeat (3) @(negedge clk);
            pop(d_t[i], w_t[i]);
        end
        reg_rd(8'h1b, 8'hb8);
        $display("test width done");

        reg_wr(8'h1b, 8'h40);
        stall = 1'b1;
        @(negedge clk);
        push(20'h11111);
        push(20'h22222);
        smp = 20'h33333;
        check({31'h0, smp_ready}, 32'h0);
        repeat (3) @(negedge clk);
        check({31'h0, smp_ready}, 32'h0);
        check({11'h0, word_valid, word.data}, {12'h1, 20'h11111});
        stall = 1'b0;
        push(20'h33333);
        smp_valid = 1'b0;
        repeat (4) @(negedge clk);
        check(rx.got_q.size(), 32'h3);
        for (int i = 1; i < 4; i++) begin
            got = rx.got_q.pop_front();
            check({12'h0, got.data}, {12'h0, {5{i[3:0]}}});
        end
        check({31'h0, hold_err}, 32'h0);
        $display("test buffer stall done");

        @(negedge clk);
        ce = 1'b0;
        reg_wr(8'h1a, 8'h40);
        check({30'h0, half, smp_ready}, 32'h0);
        ce = 1'b1;
        reg_rd(8'h1a, 8'h00);
        $display("test clock enable done");
        final_report();
    end
endmodule
